// file: logic/cpr_regs_map.vh
`ifndef CPR_REGS_MAP_VH
`define CPR_REGS_MAP_VH

// ********************************************************************
// Register offsets on the serial host port.
// ********************************************************************
`define CPR_ADDR_W 16
`define CPR_OFS_OUTPUT_SOURCE 16'h0063
`define CPR_OFS_RESERVED_64 16'h0064
`define CPR_OFS_RESERVED_65 16'h0065
`define CPR_OFS_RESERVED_66 16'h0066
`define CPR_OFS_RESERVED_67 16'h0067
`define CPR_OFS_LOOP_FILTER 16'h0068
`define CPR_OFS_PLL_MODE 16'h0069
`define CPR_OFS_MANUAL_OSC 16'h006A
`define CPR_OFS_RESERVED_6B 16'h006B
`define CPR_OFS_PUMP_CURRENT 16'h006C

// ********************************************************************
// Field positions.
// ********************************************************************
`define CPR_BIT_SYNC_HOLD 7
`define CPR_SEL_HI 5
`define CPR_SEL_LO 4
`define CPR_RES_HI 5
`define CPR_RES_LO 3
`define CPR_CAP_HI 2
`define CPR_CAP_LO 1
`define CPR_BIT_BYPASS 0
`define CPR_BIT_CRYSTAL_ONLY 3
`define CPR_BIT_TIME_DIGITIZER_DISABLE 2
`define CPR_BIT_CNT_WIDTH 1
`define CPR_BIT_MANUAL_LOCK 0
`define CPR_OSC_HI 7
`define CPR_OSC_LO 5
`define CPR_LOCKSET_HI 4
`define CPR_LOCKSET_LO 0
`define CPR_PUMP_HI 4
`define CPR_PUMP_LO 0

// ********************************************************************
// Reset values of the fields.
// ********************************************************************
`define CPR_RST_SYNC_HOLD 1'h0
`define CPR_RST_SOURCE_SEL 2'h0
`define CPR_RST_SOURCE_EN 4'h1
`define CPR_RST_SERIES_RES 3'h1
`define CPR_RST_POLE_CAP 2'h1
`define CPR_RST_POLE_BYPASS 1'h1
`define CPR_RST_TIME_DIGITIZER_DISABLE 1'h0
`define CPR_RST_CRYSTAL_ONLY 1'h0
`define CPR_RST_CNT_WIDTH 1'h1
`define CPR_RST_MANUAL_LOCK 1'h0
`define CPR_RST_OSC_SEL 3'h1
`define CPR_RST_LOCK_SET 5'h0B
`define CPR_RST_PUMP 5'h00

// ********************************************************************
// Source codes for the fourth output and lock counter widths.
// ********************************************************************
`define CPR_SRC_PLL 2'h0
`define CPR_SRC_REF0 2'h1
`define CPR_SRC_REF1 2'h2
`define CPR_SRC_XTAL 2'h3
`define CPR_LOCK_WIDE 20
`define CPR_LOCK_NARROW 16

`endif

// file: logic/cpr_divider_sync.v
`timescale 1ns/1ps

// ********************************************************************
// Output divider synchronisation: hold while set, common release.
// ********************************************************************
module cpr_divider_sync (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Sync hold bit from the register file.
  input wire syncHold,
  // Divider controls.
  output reg dividerHold_q,
  output reg dividerRelease_q
);

  // Held bit delayed by one cycle, used to find the falling edge.
  reg syncHoldDly_q;

  // One flop drives every divider reset, so all dividers leave reset on the
  // same clock edge; separate flops per divider could skew by a cycle.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncHoldDly_q <= 1'h0;
      dividerHold_q <= 1'h0;
      dividerRelease_q <= 1'h0;
    end
    else
    begin
      syncHoldDly_q <= syncHold;
      // Dividers stay in reset exactly as long as the bit reads one.
      dividerHold_q <= syncHold;
      // A single pulse marks the common release point.
      dividerRelease_q <= syncHoldDly_q & ~syncHold;
    end
  end

endmodule

// file: logic/cpr_lock_counter.v
`timescale 1ns/1ps

// ********************************************************************
// Digital lock counter for the analog PLL, 16 or 20 bits wide.
// ********************************************************************
module cpr_lock_counter #(
  parameter WIDE_BITS = 20,
  parameter NARROW_BITS = 16
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Width choice: one selects the wide accumulator.
  input wire wideCount,
  // Comparison results, already in the clock domain.
  input wire phaseTick,
  input wire phaseInWindow,
  // Lock indication.
  output reg lockDetected_q
);

  // Accumulator of consecutive in-window comparisons.
  reg [WIDE_BITS-1:0] count_q;
  // Terminal count for the selected width.
  wire [WIDE_BITS-1:0] termCount;
  // Full-scale values of both widths.
  wire [WIDE_BITS-1:0] wideFull;
  wire [WIDE_BITS-1:0] narrowFull;

  assign wideFull = {WIDE_BITS{1'b1}};
  assign narrowFull = {{(WIDE_BITS-NARROW_BITS){1'b0}}, {NARROW_BITS{1'b1}}};
  // The width bit only moves the terminal count.
  assign termCount = wideCount ? wideFull : narrowFull;

  // Any out-of-window comparison restarts the count and drops lock.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_q <= {WIDE_BITS{1'b0}};
      lockDetected_q <= 1'h0;
    end
    else if (phaseTick)
    begin
      if (!phaseInWindow)
      begin
        count_q <= {WIDE_BITS{1'b0}};
        lockDetected_q <= 1'h0;
      end
      else if (count_q >= termCount)
      begin
        // Saturate; a narrowed width also reaches lock at once.
        lockDetected_q <= 1'h1;
      end
      else
      begin
        count_q <= count_q + {{(WIDE_BITS-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// file: logic/cpr_clock_pll_regs.v
// Summary of operation
// - Sync bit one holds output dividers reset.
// - Sync bit falling releases all dividers together.
// - Two-bit selector picks fourth output source.
// - Reserved bits written zero, read undefined.
// - Three-bit series resistance code, reset 001b.
// - Two-bit second-pole capacitance code, reset 01b.
// - Bypass bit one skips second pole.
// - Converter disable bit, reset zero, enabled.
// - Crystal-only bit selects pure synthesis mode.
// - Width bit picks 20- or 16-bit counter.
`timescale 1ns/1ps
`include "cpr_regs_map.vh"

module cpr_clock_pll_regs #(
  parameter LOCK_WIDE_BITS = `CPR_LOCK_WIDE,
  parameter LOCK_NARROW_BITS = `CPR_LOCK_NARROW
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Register access from the serial host port engine.
  input wire [`CPR_ADDR_W-1:0] hostAddr,
  input wire hostWrEn,
  input wire [7:0] hostWrData,
  input wire hostRdEn,
  output reg [7:0] hostRdData_q,
  output reg hostRdValid_q,
  // Output divider synchronisation.
  output wire dividerHold_q,
  output wire dividerRelease_q,
  // Fourth output source: code and one-hot enables.
  output reg [1:0] fourthOutputSourceSelect_q,
  output reg [3:0] fourthSourceEnable_q,
  // Analog loop filter settings.
  output reg [2:0] filterSeriesResistance_q,
  output reg [1:0] secondPoleCapacitance_q,
  output reg secondPoleBypass_q,
  // PLL mode settings.
  output reg timeDigitizerDisable_q,
  output reg crystalOnlySynthesis_q,
  output reg lockCounterWidth_q,
  output reg lockManualOverride_q,
  output reg [2:0] manualOscillatorSelect_q,
  output reg [4:0] manualLockSetting_q,
  output reg [4:0] pumpCurrentCode_q,
  // Lock comparison pins from the analog PLL, asynchronous.
  input wire phaseTickPin,
  input wire phaseInWindowPin,
  // Lock indication.
  output wire lockDetected_q
);

  // ******************************************************************
  // Functions.
  // ******************************************************************

  // Turns a source code into one enable per possible source.
  function [3:0] sourceOneHot;
    input [1:0] code;
    begin
      case (code)
        `CPR_SRC_PLL: sourceOneHot = 4'h1;
        `CPR_SRC_REF0: sourceOneHot = 4'h2;
        `CPR_SRC_REF1: sourceOneHot = 4'h4;
        `CPR_SRC_XTAL: sourceOneHot = 4'h8;
        default: sourceOneHot = 4'h1;
      endcase
    end
  endfunction

  // ******************************************************************
  // Address decode.
  // ******************************************************************

  // One strobe per writable register.
  wire wrSource;
  wire wrFilter;
  wire wrMode;
  wire wrOsc;
  wire wrPump;
  // Sync hold bit as stored.
  reg syncHoldBit_q;

  // Writes to reserved offsets fall through every strobe and are dropped,
  // since nothing there may hold state.
  assign wrSource = hostWrEn & (hostAddr == `CPR_OFS_OUTPUT_SOURCE);
  assign wrFilter = hostWrEn & (hostAddr == `CPR_OFS_LOOP_FILTER);
  assign wrMode = hostWrEn & (hostAddr == `CPR_OFS_PLL_MODE);
  assign wrOsc = hostWrEn & (hostAddr == `CPR_OFS_MANUAL_OSC);
  assign wrPump = hostWrEn & (hostAddr == `CPR_OFS_PUMP_CURRENT);

  // ******************************************************************
  // Output source control register.
  // ******************************************************************

  // The enables follow the code one cycle later, so the switch point is
  // a clean register edge rather than a decode glitch.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncHoldBit_q <= `CPR_RST_SYNC_HOLD;
      fourthOutputSourceSelect_q <= `CPR_RST_SOURCE_SEL;
      fourthSourceEnable_q <= `CPR_RST_SOURCE_EN;
    end
    else
    begin
      if (wrSource)
      begin
        // Reserved positions are not stored.
        syncHoldBit_q <= hostWrData[`CPR_BIT_SYNC_HOLD];
        fourthOutputSourceSelect_q <= hostWrData[`CPR_SEL_HI:`CPR_SEL_LO];
      end
      // Exactly one source drives the fourth output.
      fourthSourceEnable_q <= sourceOneHot(fourthOutputSourceSelect_q);
    end
  end

  // ******************************************************************
  // Loop filter register.
  // ******************************************************************

  // Codes pass straight to the analog filter; values are not checked
  // because every code is a legal setting.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      filterSeriesResistance_q <= `CPR_RST_SERIES_RES;
      secondPoleCapacitance_q <= `CPR_RST_POLE_CAP;
      secondPoleBypass_q <= `CPR_RST_POLE_BYPASS;
    end
    else if (wrFilter)
    begin
      // Eight resistor codes.
      filterSeriesResistance_q <= hostWrData[`CPR_RES_HI:`CPR_RES_LO];
      // Four capacitor codes.
      secondPoleCapacitance_q <= hostWrData[`CPR_CAP_HI:`CPR_CAP_LO];
      // One bypasses the second pole.
      secondPoleBypass_q <= hostWrData[`CPR_BIT_BYPASS];
    end
  end

  // ******************************************************************
  // PLL mode register.
  // ******************************************************************

  // The free-run forcing that must go with crystal-only mode lives in the
  // digital PLL block; this bank does not enforce it.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timeDigitizerDisable_q <= `CPR_RST_TIME_DIGITIZER_DISABLE;
      crystalOnlySynthesis_q <= `CPR_RST_CRYSTAL_ONLY;
      lockCounterWidth_q <= `CPR_RST_CNT_WIDTH;
      lockManualOverride_q <= `CPR_RST_MANUAL_LOCK;
    end
    else if (wrMode)
    begin
      // One turns the converter off.
      timeDigitizerDisable_q <= hostWrData[`CPR_BIT_TIME_DIGITIZER_DISABLE];
      // One makes the PLL a crystal-only synthesizer.
      crystalOnlySynthesis_q <= hostWrData[`CPR_BIT_CRYSTAL_ONLY];
      // Lock counter width.
      lockCounterWidth_q <= hostWrData[`CPR_BIT_CNT_WIDTH];
      lockManualOverride_q <= hostWrData[`CPR_BIT_MANUAL_LOCK];
    end
  end

  // ******************************************************************
  // Manual oscillator and pump current registers.
  // ******************************************************************

  // These fill every bit of their byte apart from the pump's top three.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      manualOscillatorSelect_q <= `CPR_RST_OSC_SEL;
      manualLockSetting_q <= `CPR_RST_LOCK_SET;
      pumpCurrentCode_q <= `CPR_RST_PUMP;
    end
    else
    begin
      if (wrOsc)
      begin
        // Stored and read back as written.
        manualOscillatorSelect_q <= hostWrData[`CPR_OSC_HI:`CPR_OSC_LO];
        manualLockSetting_q <= hostWrData[`CPR_LOCKSET_HI:`CPR_LOCKSET_LO];
      end
      if (wrPump)
      begin
        pumpCurrentCode_q <= hostWrData[`CPR_PUMP_HI:`CPR_PUMP_LO];
      end
    end
  end

  // ******************************************************************
  // Read path.
  // ******************************************************************

  // Read byte assembled from the current field values.
  reg [7:0] rdMux;

  // Reserved positions and reserved offsets return zero; software must
  // not rely on that.
  always @*
  begin
    rdMux = 8'h00;
    case (hostAddr)
      `CPR_OFS_OUTPUT_SOURCE:
      begin
        rdMux[`CPR_BIT_SYNC_HOLD] = syncHoldBit_q;
        rdMux[`CPR_SEL_HI:`CPR_SEL_LO] = fourthOutputSourceSelect_q;
      end
      `CPR_OFS_LOOP_FILTER:
      begin
        rdMux[`CPR_RES_HI:`CPR_RES_LO] = filterSeriesResistance_q;
        rdMux[`CPR_CAP_HI:`CPR_CAP_LO] = secondPoleCapacitance_q;
        rdMux[`CPR_BIT_BYPASS] = secondPoleBypass_q;
      end
      `CPR_OFS_PLL_MODE:
      begin
        rdMux[`CPR_BIT_TIME_DIGITIZER_DISABLE] = timeDigitizerDisable_q;
        rdMux[`CPR_BIT_CRYSTAL_ONLY] = crystalOnlySynthesis_q;
        rdMux[`CPR_BIT_CNT_WIDTH] = lockCounterWidth_q;
        rdMux[`CPR_BIT_MANUAL_LOCK] = lockManualOverride_q;
      end
      `CPR_OFS_MANUAL_OSC:
      begin
        rdMux[`CPR_OSC_HI:`CPR_OSC_LO] = manualOscillatorSelect_q;
        rdMux[`CPR_LOCKSET_HI:`CPR_LOCKSET_LO] = manualLockSetting_q;
      end
      `CPR_OFS_PUMP_CURRENT:
      begin
        rdMux[`CPR_PUMP_HI:`CPR_PUMP_LO] = pumpCurrentCode_q;
      end
      default:
      begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Read data is registered; it holds until the next read.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hostRdData_q <= 8'h00;
      hostRdValid_q <= 1'h0;
    end
    else
    begin
      hostRdValid_q <= hostRdEn;
      if (hostRdEn)
      begin
        // Reads return the stored fields, with zero in reserved positions and offsets.
        hostRdData_q <= rdMux;
      end
    end
  end

  // ******************************************************************
  // Pin synchronisers for the lock comparison inputs.
  // ******************************************************************

  // Two-stage synchronisers; only the second stage is read further on.
  reg [1:0] tickMeta_q;
  reg [1:0] windowMeta_q;
  reg tickSyncDly_q;
  // Fills with ones over the first edges after reset; until it is full the
  // delayed copy may not match the pin yet, so any edge seen then is false.
  reg [2:0] tickArmed_q;
  wire tickEdge;

  // The tick pin is a level toggled per comparison, so an edge is one
  // event; it must change slower than half the clock rate.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickMeta_q <= 2'h0;
      windowMeta_q <= 2'h0;
      tickSyncDly_q <= 1'h0;
      tickArmed_q <= 3'h0;
    end
    else
    begin
      tickMeta_q <= {tickMeta_q[0], phaseTickPin};
      windowMeta_q <= {windowMeta_q[0], phaseInWindowPin};
      tickSyncDly_q <= tickMeta_q[1];
      tickArmed_q <= {tickArmed_q[1:0], 1'h1};
    end
  end

  // A pin left high through reset would otherwise look like a toggle. The
  // price is that a real toggle before the first edge after reset is not counted.
  assign tickEdge = tickArmed_q[2] & (tickMeta_q[1] ^ tickSyncDly_q);

  // ******************************************************************
  // Submodules.
  // ******************************************************************

  // Divider hold and common release.
  cpr_divider_sync uSync (
    .clk(clk),
    .rst_b(rst_b),
    .syncHold(syncHoldBit_q),
    .dividerHold_q(dividerHold_q),
    .dividerRelease_q(dividerRelease_q)
  );

  // Lock accumulator whose width the mode register sets.
  cpr_lock_counter #(
    .WIDE_BITS(LOCK_WIDE_BITS),
    .NARROW_BITS(LOCK_NARROW_BITS)
  ) uLock (
    .clk(clk),
    .rst_b(rst_b),
    .wideCount(lockCounterWidth_q),
    .phaseTick(tickEdge),
    .phaseInWindow(windowMeta_q[1]),
    .lockDetected_q(lockDetected_q)
  );

endmodule

// file: verification/cpr_clock_pll_regs_sva.sv
`timescale 1ns/1ps
`include "cpr_regs_map.vh"

// ****************************************************************
// Port-level checker for the clock source and PLL control registers.
// ****************************************************************
module cpr_clock_pll_regs_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Host access.
  input wire logic [15:0] hostAddr,
  input wire logic hostWrEn,
  input wire logic [7:0] hostWrData,
  input wire logic hostRdEn,
  input wire logic [7:0] hostRdData_q,
  input wire logic hostRdValid_q,
  // Register outputs.
  input wire logic dividerHold_q,
  input wire logic dividerRelease_q,
  input wire logic [1:0] fourthOutputSourceSelect_q,
  input wire logic [3:0] fourthSourceEnable_q,
  input wire logic [2:0] filterSeriesResistance_q,
  input wire logic [1:0] secondPoleCapacitance_q,
  input wire logic secondPoleBypass_q,
  input wire logic timeDigitizerDisable_q,
  input wire logic crystalOnlySynthesis_q,
  input wire logic lockCounterWidth_q
);
  // All checks share one clock; reset aborts attempts in flight.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Writes to the source register reach the hold two edges later.
  AST_HOLD_FOLLOWS: assert property (
    hostWrEn && hostAddr == `CPR_OFS_OUTPUT_SOURCE |->
    ##2 dividerHold_q == $past(hostWrData[7], 2))
    else $error("divider hold wrong");
  // The release pulse marks exactly the edge on which the hold falls.
  AST_COMMON_RELEASE: assert property (
    dividerRelease_q == ($past(dividerHold_q) && !dividerHold_q))
    else $error("release pulse wrong");
  // The stored source code is the written one.
  AST_SOURCE_WRITE: assert property (
    hostWrEn && hostAddr == `CPR_OFS_OUTPUT_SOURCE |=>
    fourthOutputSourceSelect_q == $past(hostWrData[5:4]))
    else $error("source code wrong");
  // The enables trail the code by one cycle and are always one-hot.
  AST_SOURCE_ONEHOT: assert property (
    ##1 fourthSourceEnable_q == (4'h1 << $past(fourthOutputSourceSelect_q)))
    else $error("source enable wrong");
  // Filter fields take the written bits at the next edge.
  AST_FILTER_WRITE: assert property (
    hostWrEn && hostAddr == `CPR_OFS_LOOP_FILTER |=>
    {filterSeriesResistance_q, secondPoleCapacitance_q, secondPoleBypass_q} ==
    $past(hostWrData[5:0]))
    else $error("filter fields wrong");
  // Mode fields take the written bits at the next edge.
  AST_MODE_WRITE: assert property (
    hostWrEn && hostAddr == `CPR_OFS_PLL_MODE |=>
    {crystalOnlySynthesis_q, timeDigitizerDisable_q, lockCounterWidth_q} ==
    $past(hostWrData[3:1]))
    else $error("mode fields wrong");
  // A read with no write beside it returns the stored fields.
  AST_FILTER_READBACK: assert property (
    hostRdEn && !hostWrEn && hostAddr == `CPR_OFS_LOOP_FILTER |=>
    hostRdValid_q && hostRdData_q ==
    {2'h0, filterSeriesResistance_q, secondPoleCapacitance_q, secondPoleBypass_q})
    else $error("filter readback wrong");
  // Reserved offsets hold nothing and read as zero.
  AST_RESERVED_READ: assert property (
    hostRdEn && (hostAddr inside {[16'h0064:16'h0067], 16'h006B}) |=>
    hostRdData_q == 8'h00)
    else $error("reserved read not zero");
  // Without a write the filter fields and counter width may not move.
  AST_FIELDS_HOLD: assert property (
    !hostWrEn |=> $stable({filterSeriesResistance_q, secondPoleCapacitance_q,
    secondPoleBypass_q, lockCounterWidth_q}))
    else $error("field drifted");
endmodule

bind cpr_clock_pll_regs cpr_clock_pll_regs_sva i_cpr_clock_pll_regs_sva (.*);

// file: verification/cpr_clock_pll_regs_bench.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench; inputs change on the falling edge.
// ****************************************************************
module cpr_clock_pll_regs_bench;
  logic clk, rst_b, hostWrEn, hostRdEn, phaseTickPin, phaseInWindowPin;
  logic [15:0] hostAddr;
  logic [7:0] hostWrData;
  wire [7:0] hostRdData_q;
  wire hostRdValid_q, dividerHold_q, dividerRelease_q, secondPoleBypass_q, lockDetected_q;
  wire [1:0] fourthOutputSourceSelect_q, secondPoleCapacitance_q;
  wire [3:0] fourthSourceEnable_q;
  wire [2:0] filterSeriesResistance_q, manualOscillatorSelect_q;
  wire timeDigitizerDisable_q, crystalOnlySynthesis_q, lockCounterWidth_q, lockManualOverride_q;
  wire [4:0] manualLockSetting_q, pumpCurrentCode_q;
  int errors = 0;
  int tests_run = 0;
  // Rows: address, write data, expected read back. Reserved positions are
  // always written as zero; source rows assume slow references.
  // The crystal-only row leaves free-run forcing to the digital PLL.
  logic [31:0] rows [12] = '{32'h0063_1010, 32'h0063_2020, 32'h0063_3030, 32'h0063_0000,
    32'h0068_3F3F, 32'h0068_0000, 32'h0069_0E0E, 32'h0069_0101, 32'h006A_FFFF,
    32'h006C_1F1F, 32'h0064_0000, 32'h0070_FF00};

  // Short counts so the lock indication is reachable in a few ticks.
  cpr_clock_pll_regs #(.LOCK_WIDE_BITS(4), .LOCK_NARROW_BITS(2)) i_cpr_clock_pll_regs (
    .clk(clk), .rst_b(rst_b), .hostAddr(hostAddr), .hostWrEn(hostWrEn),
    .hostWrData(hostWrData), .hostRdEn(hostRdEn), .hostRdData_q(hostRdData_q),
    .hostRdValid_q(hostRdValid_q), .dividerHold_q(dividerHold_q),
    .dividerRelease_q(dividerRelease_q),
    .fourthOutputSourceSelect_q(fourthOutputSourceSelect_q),
    .fourthSourceEnable_q(fourthSourceEnable_q),
    .filterSeriesResistance_q(filterSeriesResistance_q),
    .secondPoleCapacitance_q(secondPoleCapacitance_q), .secondPoleBypass_q(secondPoleBypass_q),
    .timeDigitizerDisable_q(timeDigitizerDisable_q),
    .crystalOnlySynthesis_q(crystalOnlySynthesis_q), .lockCounterWidth_q(lockCounterWidth_q),
    .lockManualOverride_q(lockManualOverride_q),
    .manualOscillatorSelect_q(manualOscillatorSelect_q),
    .manualLockSetting_q(manualLockSetting_q), .pumpCurrentCode_q(pumpCurrentCode_q),
    .phaseTickPin(phaseTickPin), .phaseInWindowPin(phaseInWindowPin),
    .lockDetected_q(lockDetected_q));

  // 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares a seen value with an expected one and counts both outcomes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One bus cycle: drive at a falling edge, return at the next one.
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    hostWrEn = w;
    hostRdEn = r;
    hostAddr = a;
    hostWrData = d;
    @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'h1, 1'h0, a, d);
    bus(1'h0, 1'h0, 16'h0000, 8'h00);
  endtask

  // Read data and valid are registered, so they are seen one cycle on.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus(1'h0, 1'h1, a, 8'h00);
    check(hostRdValid_q, 1'h1);
    check(hostRdData_q, exp);
    bus(1'h0, 1'h0, 16'h0000, 8'h00);
    check(hostRdValid_q, 1'h0);
  endtask

  // One lock comparison; toggles are kept well apart for the synchroniser.
  task automatic tick(input logic win);
    phaseInWindowPin = win;
    phaseTickPin = ~phaseTickPin;
    repeat (4) @(negedge clk);
  endtask

  // A run should last well under a thousand cycles; this cuts off a hang.
  initial
  begin
    #100000;
    errors++;
    stop_test();
  end

  initial
  begin
    {rst_b, hostWrEn, hostRdEn, phaseTickPin, phaseInWindowPin} = 5'h00;
    hostAddr = 16'h0000;
    hostWrData = 8'h00;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    // ****************************************************************
    // Table of writes and read backs, reserved and unmapped included.
    // ****************************************************************
    foreach (rows[i])
    begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], rows[i][7:0]);
      if (rows[i][31:16] == 16'h0063)
      begin
        check(fourthOutputSourceSelect_q, rows[i][13:12]);
        check(fourthSourceEnable_q, 4'h1 << rows[i][13:12]);
      end
    end
    check({crystalOnlySynthesis_q, timeDigitizerDisable_q, lockCounterWidth_q}, 3'h0);
    check({lockManualOverride_q, manualOscillatorSelect_q, manualLockSetting_q, pumpCurrentCode_q},
      14'h3FFF);
    $display("table test done");
    // Hold while the sync bit is one, then one common release pulse.
    wr(16'h0063, 8'h80);
    repeat (5) @(negedge clk);
    check({dividerHold_q, dividerRelease_q}, 2'h2);
    wr(16'h0063, 8'h00);
    check({dividerHold_q, dividerRelease_q}, 2'h1);
    @(negedge clk);
    check({dividerHold_q, dividerRelease_q}, 2'h0);
    $display("sync test done");
    // Back-to-back writes, then a read in the same cycle as a write.
    bus(1'h1, 1'h0, 16'h0068, 8'h3F);
    bus(1'h1, 1'h0, 16'h006C, 8'h15);
    bus(1'h1, 1'h1, 16'h0068, 8'h00);
    check(hostRdData_q, 8'h3F);
    bus(1'h0, 1'h0, 16'h0000, 8'h00);
    rd(16'h006C, 8'h15);
    check({filterSeriesResistance_q, secondPoleCapacitance_q, secondPoleBypass_q},
      6'h00);
    $display("back to back test done");
    // Narrow counter locks within six ticks; a miss clears it.
    wr(16'h0069, 8'h00);
    repeat (3) tick(1'h1);
    check(lockDetected_q, 1'h0);
    repeat (3) tick(1'h1);
    check(lockDetected_q, 1'h1);
    tick(1'h0);
    check(lockDetected_q, 1'h0);
    // The wide counter needs far more ticks than the narrow one.
    wr(16'h0069, 8'h02);
    repeat (6) tick(1'h1);
    check(lockDetected_q, 1'h0);
    $display("lock test done");
    // ****************************************************************
    // Reset in mid-run returns every field to its default.
    // ****************************************************************
    rst_b = 1'b0;
    @(negedge clk);
    check({dividerHold_q, dividerRelease_q, fourthOutputSourceSelect_q, fourthSourceEnable_q},
      8'h01);
    check({filterSeriesResistance_q, secondPoleCapacitance_q, secondPoleBypass_q},
      6'h0B);
    check({lockManualOverride_q, manualOscillatorSelect_q, manualLockSetting_q, pumpCurrentCode_q},
      14'h0560);
    check({timeDigitizerDisable_q, crystalOnlySynthesis_q, lockCounterWidth_q}, 3'h1);
    rst_b = 1'b1;
    @(negedge clk);
    rd(16'h0068, 8'h0B);
    rd(16'h0069, 8'h02);
    rd(16'h006A, 8'h2B);
    rd(16'h006C, 8'h00);
    // The tick pin stayed high through reset; that level is not a tick.
    wr(16'h0069, 8'h00);
    repeat (3) tick(1'h1);
    check(lockDetected_q, 1'h0);
    tick(1'h1);
    check(lockDetected_q, 1'h1);
    $display("reset test done");
    stop_test();
  end
endmodule
